// ==== verilog/rfm_reg_bank.sv ====
/*
 * Reference frequency mode register bank with an AXI4-Lite slave.
 * Holds the per-input mode fields and the custom A settings, and steers
 * each input's monitor configuration from them.
 * Assumes one clock, a synchronous active-low reset, and a master that
 * keeps at most one write and one read outstanding.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
// Summary of operation
// - Two-bit mode: auto, custom A, custom B, reserved
// - Inputs 0-3 modes in first mode register
// - Inputs 4-7 modes in second mode register
// - Custom A rate is 14-bit multiple of 8 kHz
// - Multiplier bits 13:8 in high byte, 7:6 reserved
// - Short-cycle monitor lower limit, 8 bits
// - Short-cycle monitor upper limit, 8 bits
// - Coarse monitor low limit low byte
// - Every register resets to zero
// - Coarse monitor low limit high byte
`timescale 1ns/1ps

module rfm_reg_bank
  import rfm_pkg::*;
#(
  parameter int NUM_INPUTS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [RFM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [RFM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-input monitor configuration
  output rfm_monitor_cfg_t monitor_cfg [NUM_INPUTS]
);

  // ==========================================================
  // Register storage
  // ==========================================================
  logic [7:0] input_freq_mode_low_r, input_freq_mode_low_nxt;
  logic [7:0] input_freq_mode_high_r, input_freq_mode_high_nxt;
  logic [7:0] custom_a_multiplier_lo_r, custom_a_multiplier_lo_nxt;
  logic [5:0] custom_a_multiplier_hi_r, custom_a_multiplier_hi_nxt;
  logic [7:0] custom_a_short_monitor_low_limit_r;
  logic [7:0] custom_a_short_monitor_low_limit_nxt;
  logic [7:0] custom_a_short_monitor_high_limit_r;
  logic [7:0] custom_a_short_monitor_high_limit_nxt;
  logic [7:0] custom_a_coarse_monitor_low_limit_lo_r;
  logic [7:0] custom_a_coarse_monitor_low_limit_lo_nxt;
  logic [7:0] custom_a_coarse_monitor_low_limit_hi_r;
  logic [7:0] custom_a_coarse_monitor_low_limit_hi_nxt;

  // ==========================================================
  // Bus slave state
  // ==========================================================
  logic aw_held_r, aw_held_nxt; // Write address captured
  logic w_held_r, w_held_nxt; // Write data captured
  logic [RFM_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt; // Only lane 0 carries data
  logic w_lane0_r, w_lane0_nxt; // Byte lane 0 enabled
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  rfm_monitor_cfg_t cfg_r [NUM_INPUTS];
  rfm_monitor_cfg_t cfg_nxt [NUM_INPUTS];

  // Register-word decode of a byte address; unaligned addresses miss
  function automatic logic [7:0] word_of(input logic [RFM_ADDR_W-1:0] a);
    word_of = a[9:2];
  endfunction : word_of

  function automatic logic is_mapped(input logic [RFM_ADDR_W-1:0] a);
    logic [7:0] w;
    w = word_of(a);
    is_mapped = (a[1:0] == 2'h0) && (w >= RFM_IDX_MODE_LOW)
      && (w <= RFM_IDX_COARSE_HI);
  endfunction : is_mapped

  // ==========================================================
  // Write path: accept address and data in either order
  // ==========================================================
  logic do_write;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    aw_addr_nxt = aw_addr_r;
    w_byte_nxt = w_byte_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    // Ready only while the channel slot is empty
    awready_nxt = !aw_held_r && !(s_axi_awvalid && awready_r);
    wready_nxt = !w_held_r && !(s_axi_wvalid && wready_r);
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_lane0_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      // Both halves present: commit and answer
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = is_mapped(aw_addr_r) ? RFM_RESP_OKAY : RFM_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    // Hold both readies low while a response is pending
    if (bvalid_nxt) begin
      awready_nxt = 1'b0;
      wready_nxt = 1'b0;
    end
  end

  // ==========================================================
  // Register update from a committed write
  // ==========================================================
  always_comb begin
    logic [7:0] w;
    w = word_of(aw_addr_r);
    input_freq_mode_low_nxt = input_freq_mode_low_r;
    input_freq_mode_high_nxt = input_freq_mode_high_r;
    custom_a_multiplier_lo_nxt = custom_a_multiplier_lo_r;
    custom_a_multiplier_hi_nxt = custom_a_multiplier_hi_r;
    custom_a_short_monitor_low_limit_nxt = custom_a_short_monitor_low_limit_r;
    custom_a_short_monitor_high_limit_nxt =
      custom_a_short_monitor_high_limit_r;
    custom_a_coarse_monitor_low_limit_lo_nxt =
      custom_a_coarse_monitor_low_limit_lo_r;
    custom_a_coarse_monitor_low_limit_hi_nxt =
      custom_a_coarse_monitor_low_limit_hi_r;
    // A cleared strobe on lane 0 leaves the register untouched
    if (do_write && w_lane0_r && is_mapped(aw_addr_r)) begin
      if (w == RFM_IDX_MODE_LOW) begin
        input_freq_mode_low_nxt = w_byte_r;
      end else if (w == RFM_IDX_MODE_HIGH) begin
        input_freq_mode_high_nxt = w_byte_r;
      end else if (w == RFM_IDX_MULT_LO) begin
        custom_a_multiplier_lo_nxt = w_byte_r;
      end else if (w == RFM_IDX_MULT_HI) begin
        // Reserved bits 7:6 are not stored and read as zero
        custom_a_multiplier_hi_nxt = w_byte_r[RFM_MULT_HI_W-1:0];
      end else if (w == RFM_IDX_SHORT_LOW) begin
        custom_a_short_monitor_low_limit_nxt = w_byte_r;
      end else if (w == RFM_IDX_SHORT_HIGH) begin
        custom_a_short_monitor_high_limit_nxt = w_byte_r;
      end else if (w == RFM_IDX_COARSE_LO) begin
        custom_a_coarse_monitor_low_limit_lo_nxt = w_byte_r;
      end else begin
        custom_a_coarse_monitor_low_limit_hi_nxt = w_byte_r;
      end
    end
  end

  // ==========================================================
  // Read path: one read at a time, answer one cycle after address
  // ==========================================================
  always_comb begin
    logic [7:0] w;
    w = word_of(s_axi_araddr);
    arready_nxt = !rvalid_r; // Ready whenever no answer is pending
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = is_mapped(s_axi_araddr) ? RFM_RESP_OKAY : RFM_RESP_SLVERR;
      rdata_nxt = 32'h0000_0000; // Unused upper bits read zero
      if (!is_mapped(s_axi_araddr)) begin
        rdata_nxt = 32'h0000_0000;
      end else if (w == RFM_IDX_MODE_LOW) begin
        rdata_nxt[7:0] = input_freq_mode_low_r;
      end else if (w == RFM_IDX_MODE_HIGH) begin
        rdata_nxt[7:0] = input_freq_mode_high_r;
      end else if (w == RFM_IDX_MULT_LO) begin
        rdata_nxt[7:0] = custom_a_multiplier_lo_r;
      end else if (w == RFM_IDX_MULT_HI) begin
        rdata_nxt[7:0] = {2'h0, custom_a_multiplier_hi_r};
      end else if (w == RFM_IDX_SHORT_LOW) begin
        rdata_nxt[7:0] = custom_a_short_monitor_low_limit_r;
      end else if (w == RFM_IDX_SHORT_HIGH) begin
        rdata_nxt[7:0] = custom_a_short_monitor_high_limit_r;
      end else if (w == RFM_IDX_COARSE_LO) begin
        rdata_nxt[7:0] = custom_a_coarse_monitor_low_limit_lo_r;
      end else begin
        rdata_nxt[7:0] = custom_a_coarse_monitor_low_limit_hi_r;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // ==========================================================
  // Per-input monitor selection
  // ==========================================================
  always_comb begin
    rfm_custom_a_t cust;
    cust.multiplier = {custom_a_multiplier_hi_r,
      custom_a_multiplier_lo_r};
    cust.short_lower = custom_a_short_monitor_low_limit_r;
    cust.short_upper = custom_a_short_monitor_high_limit_r;
    cust.coarse_lower = {custom_a_coarse_monitor_low_limit_hi_r,
      custom_a_coarse_monitor_low_limit_lo_r};
    for (int i = 0; i < NUM_INPUTS; i++) begin
      rfm_mode_t m;
      logic [15:0] both;
      both = {input_freq_mode_high_r, input_freq_mode_low_r};
      m = rfm_mode_t'(both[(i % (2 * RFM_INPUTS_PER_REG)) * RFM_MODE_W
        +: RFM_MODE_W]);
      // Reserved code falls back to automatic detection
      cfg_nxt[i].use_custom_a = (m == RFM_MODE_CUSTOM_A);
      cfg_nxt[i].use_custom_b = (m == RFM_MODE_CUSTOM_B);
      cfg_nxt[i].setting = (m == RFM_MODE_CUSTOM_A) ? cust : '0;
    end
  end

  // ==========================================================
  // State registers
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_freq_mode_low_r <= RFM_RESET_BYTE;
      input_freq_mode_high_r <= RFM_RESET_BYTE;
      custom_a_multiplier_lo_r <= RFM_RESET_BYTE;
      custom_a_multiplier_hi_r <= RFM_RESET_MULT[13:8];
      custom_a_short_monitor_low_limit_r <= RFM_RESET_BYTE;
      custom_a_short_monitor_high_limit_r <= RFM_RESET_BYTE;
      custom_a_coarse_monitor_low_limit_lo_r <= RFM_RESET_BYTE;
      custom_a_coarse_monitor_low_limit_hi_r <= RFM_RESET_BYTE;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= RFM_RESET_BYTE;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RFM_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RFM_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        cfg_r[i] <= '0;
      end
    end else begin
      input_freq_mode_low_r <= input_freq_mode_low_nxt;
      input_freq_mode_high_r <= input_freq_mode_high_nxt;
      custom_a_multiplier_lo_r <= custom_a_multiplier_lo_nxt;
      custom_a_multiplier_hi_r <= custom_a_multiplier_hi_nxt;
      custom_a_short_monitor_low_limit_r <=
        custom_a_short_monitor_low_limit_nxt;
      custom_a_short_monitor_high_limit_r <=
        custom_a_short_monitor_high_limit_nxt;
      custom_a_coarse_monitor_low_limit_lo_r <=
        custom_a_coarse_monitor_low_limit_lo_nxt;
      custom_a_coarse_monitor_low_limit_hi_r <=
        custom_a_coarse_monitor_low_limit_hi_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane0_r <= w_lane0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign monitor_cfg = cfg_r;

  // ==========================================================
  // Checks
  // ==========================================================
  a_mode_custom_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (input_freq_mode_low_r[1:0] == 2'b01) |=> cfg_r[0].use_custom_a)
    else $error("Input 0 custom A not selected");
  a_mode_low_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> cfg_r[3].use_custom_b
      == ($past(input_freq_mode_low_r[7:6]) == 2'b10))
    else $error("Input 3 mode field misplaced");
  a_mode_high_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> cfg_r[6].use_custom_a
      == ($past(input_freq_mode_high_r[5:4]) == 2'b01))
    else $error("Input 6 mode field misplaced");
  a_mult_join: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_r[0].use_custom_a |-> cfg_r[0].setting.multiplier[7:0]
      == $past(custom_a_multiplier_lo_r))
    else $error("Multiplier low bits wrong");
  a_mult_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_r && rresp_r == RFM_RESP_OKAY && $past(s_axi_araddr)
      == {RFM_IDX_MULT_HI, 2'h0} |-> rdata_r[7:6] == 2'h0)
    else $error("Reserved multiplier bits read nonzero");
  a_short_low_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_lane0_r && aw_addr_r == {RFM_IDX_SHORT_LOW, 2'h0}
      |=> custom_a_short_monitor_low_limit_r == $past(w_byte_r))
    else $error("Short low limit not written");
  a_short_high_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_lane0_r && aw_addr_r == {RFM_IDX_SHORT_HIGH, 2'h0}
      |=> custom_a_short_monitor_high_limit_r == $past(w_byte_r))
    else $error("Short high limit not written");
  a_coarse_lo_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_lane0_r && aw_addr_r == {RFM_IDX_COARSE_LO, 2'h0}
      |=> ##1 (!cfg_r[1].use_custom_a
      || cfg_r[1].setting.coarse_lower[7:0] == $past(w_byte_r, 2)))
    else $error("Coarse low byte not applied");
  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> input_freq_mode_low_r == 8'h00
      && custom_a_coarse_monitor_low_limit_hi_r == 8'h00)
    else $error("Register not zero after reset");
  a_coarse_hi_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_lane0_r && aw_addr_r == {RFM_IDX_COARSE_HI, 2'h0}
      |=> custom_a_coarse_monitor_low_limit_hi_r == $past(w_byte_r))
    else $error("Coarse high byte not written");
  a_auto_no_cust: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_r[7].use_custom_a |-> cfg_r[7].setting == '0)
    else $error("Non custom A input carries custom values");

endmodule : rfm_reg_bank

// ==== verilog/rfm_pkg.sv ====
/*
 * Package for the reference frequency mode register bank: register
 * offsets, reset values, field layout, mode encoding and carrier structs.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
package rfm_pkg;

  // ==========================================================
  // Register indices; the byte address is four times the index
  // ==========================================================
  localparam logic [7:0] RFM_IDX_MODE_LOW = 8'h65;
  localparam logic [7:0] RFM_IDX_MODE_HIGH = 8'h66;
  localparam logic [7:0] RFM_IDX_MULT_LO = 8'h67;
  localparam logic [7:0] RFM_IDX_MULT_HI = 8'h68;
  localparam logic [7:0] RFM_IDX_SHORT_LOW = 8'h69;
  localparam logic [7:0] RFM_IDX_SHORT_HIGH = 8'h6a;
  localparam logic [7:0] RFM_IDX_COARSE_LO = 8'h6b;
  localparam logic [7:0] RFM_IDX_COARSE_HI = 8'h6c;
  localparam int RFM_ADDR_W = 10;

  // ==========================================================
  // Reset values and field layout
  // ==========================================================
  localparam logic [7:0] RFM_RESET_BYTE = 8'h00;
  localparam logic [13:0] RFM_RESET_MULT = 14'h0000;
  localparam logic [15:0] RFM_RESET_COARSE = 16'h0000;
  localparam int RFM_MULT_HI_W = 6;
  localparam int RFM_MODE_W = 2;
  localparam int RFM_INPUTS_PER_REG = 4;
  localparam int RFM_BASE_RATE_KHZ = 8;

  // AXI responses
  localparam logic [1:0] RFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] RFM_RESP_SLVERR = 2'h2;

  // Per-input frequency mode encoding
  typedef enum logic [1:0] {
    RFM_MODE_AUTO = 2'b00,
    RFM_MODE_CUSTOM_A = 2'b01,
    RFM_MODE_CUSTOM_B = 2'b10,
    RFM_MODE_RESERVED = 2'b11
  } rfm_mode_t;

  // Custom A setting bundle handed to the monitors
  typedef struct packed {
    logic [13:0] multiplier;
    logic [7:0] short_lower;
    logic [7:0] short_upper;
    logic [15:0] coarse_lower;
  } rfm_custom_a_t;

  // Per-input monitor setting: custom A and custom B flags plus chosen values
  typedef struct packed {
    logic use_custom_a;
    logic use_custom_b;
    rfm_custom_a_t setting;
  } rfm_monitor_cfg_t;

endpackage : rfm_pkg

// ==== test/rfm_reg_bank_bench.sv ====
/*
 * Self-checking bench for the reference frequency mode register bank.
 * Drives the AXI4-Lite slave port directly and watches monitor_cfg.
 * Assumes the rfm_pkg package is compiled first, and a 100 MHz clock.
 */
`timescale 1ns/1ps

// One compare: counts it, and reports a mismatch at once
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end

module rfm_reg_bank_bench
  import rfm_pkg::*;
();

  // ==========================================================
  // Signals
  // ==========================================================
  logic aclk = 1'b0; // Free-running clock
  logic aresetn = 1'b0; // Held low from time zero
  logic [RFM_ADDR_W-1:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [RFM_ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  rfm_monitor_cfg_t monitor_cfg [8]; // Per-input steering seen by monitors
  int num_errors = 0; // Mismatches so far
  int checks_done = 0; // Compares so far
  rfm_custom_a_t sa; // Expected custom A bundle

  // Register indices in map order, and the bytes written to them
  localparam logic [7:0] REG_IDX [8] = '{RFM_IDX_MODE_LOW,
    RFM_IDX_MODE_HIGH, RFM_IDX_MULT_LO, RFM_IDX_MULT_HI, RFM_IDX_SHORT_LOW,
    RFM_IDX_SHORT_HIGH, RFM_IDX_COARSE_LO, RFM_IDX_COARSE_HI};
  localparam logic [7:0] REG_VAL [8] = '{8'he4, 8'h19, 8'h5a, 8'hff,
    8'h12, 8'hc3, 8'h7e, 8'h81};
  // Outside the map: below, above, unaligned, far away
  localparam logic [9:0] BAD [5] = '{10'h000, 10'h190, 10'h1b4, 10'h195,
    10'h3fc};

  // ==========================================================
  // Clock and device
  // ==========================================================
  always #5 aclk = ~aclk;

  rfm_reg_bank #(.NUM_INPUTS(8)) uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .monitor_cfg(monitor_cfg)
  );

  // ==========================================================
  // Bus tasks
  // ==========================================================
  // Byte address of a register index, one word per register
  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  // Reset for 16 cycles; awready and arready must be low at its end
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    `CHK("awready in reset", 1'b0, s_axi_awready)
    `CHK("arready in reset", 1'b0, s_axi_arready)
    aresetn <= 1'b1;
  endtask : do_reset

  // Address and data offered together, each dropped once taken
  task automatic wr_chk(input logic [9:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // No fixed latency assumed; the watchdog bounds the wait
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr_chk

  // Read one word; only the low byte may be nonzero
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h000000, ed}, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd_chk

  // Expected steering of all inputs from the two mode bytes
  task automatic chk_mon(input logic [7:0] lo, input logic [7:0] hi);
    logic [1:0] code;
    rfm_monitor_cfg_t e;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      code = (i < 4) ? lo[2*i +: 2] : hi[2*(i-4) +: 2];
      e.use_custom_a = (code == 2'b01);
      e.use_custom_b = (code == 2'b10);
      e.setting = (code == 2'b01) ? sa : '0;
      `CHK("monitor_cfg", e, monitor_cfg[i])
    end
  endtask : chk_mon

  // Verdict and end of run, also reached from the watchdog
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin : main
    logic [7:0] lo;
    logic [7:0] hi;
    // Reserved top bits of the high multiplier byte never reach it
    sa.multiplier = {REG_VAL[3][5:0], REG_VAL[2]};
    sa.short_lower = REG_VAL[4];
    sa.short_upper = REG_VAL[5];
    sa.coarse_lower = {REG_VAL[7], REG_VAL[6]};
    lo = 8'h00;
    hi = 8'h00;
    do_reset();
    chk_mon(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ba(REG_IDX[i]), 8'h00, RFM_RESP_OKAY);
    end
    // Junk in the upper data bits must be ignored
    for (int i = 0; i < 8; i++) begin
      wr_chk(ba(REG_IDX[i]), {24'ha5a5a5, REG_VAL[i]}, 4'hf, RFM_RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) begin
      rd_chk(ba(REG_IDX[i]), REG_VAL[i] & ((i == 3) ? 8'h3f : 8'hff),
             RFM_RESP_OKAY);
    end
    chk_mon(REG_VAL[0], REG_VAL[1]);
    // Rotate every code through every input field
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 4; f++) begin
        lo[2*f +: 2] = 2'((f + k) % 4);
        hi[2*f +: 2] = 2'((3 - f + k) % 4);
      end
      wr_chk(ba(RFM_IDX_MODE_LOW), {24'h0, lo}, 4'hf, RFM_RESP_OKAY);
      wr_chk(ba(RFM_IDX_MODE_HIGH), {24'h0, hi}, 4'hf, RFM_RESP_OKAY);
      rd_chk(ba(RFM_IDX_MODE_LOW), lo, RFM_RESP_OKAY);
      rd_chk(ba(RFM_IDX_MODE_HIGH), hi, RFM_RESP_OKAY);
      chk_mon(lo, hi);
    end
    // Low byte lane disabled: accepted but nothing stored
    wr_chk(ba(RFM_IDX_MULT_LO), 32'h000000ff, 4'he, RFM_RESP_OKAY);
    rd_chk(ba(RFM_IDX_MULT_LO), REG_VAL[2], RFM_RESP_OKAY);
    // Addresses outside the bank are refused and store nothing
    for (int j = 0; j < 5; j++) begin
      wr_chk(BAD[j], 32'h000000ff, 4'hf, RFM_RESP_SLVERR);
      rd_chk(BAD[j], 8'h00, RFM_RESP_SLVERR);
    end
    rd_chk(ba(RFM_IDX_MODE_LOW), lo, RFM_RESP_OKAY);
    rd_chk(ba(RFM_IDX_COARSE_HI), REG_VAL[7], RFM_RESP_OKAY);
    chk_mon(lo, hi);
    // Second reset in mid-run clears everything again
    do_reset();
    chk_mon(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ba(REG_IDX[i]), 8'h00, RFM_RESP_OKAY);
    end
    summarize();
  end

  // ==========================================================
  // Watchdog: the tests need well under a thousand cycles
  // ==========================================================
  initial begin : watchdog
    repeat (5000) @(posedge aclk);
    num_errors++;
    summarize();
  end

endmodule : rfm_reg_bank_bench
